// ### rtl/mapp_map.svh
// Constants of the muxed address programming port.
// Assumes inclusion by mapp_pkg and mapp_top only.
`ifndef MAPP_MAP_SVH
`define MAPP_MAP_SVH
// Widths of the row, column and combined array address
`define MAPP_ROW_W     11
`define MAPP_COL_W     8
`define MAPP_ADDR_W    19
`define MAPP_DATA_W    8
`define MAPP_GPI_W     5
// Position of the done flag inside the status byte
`define MAPP_DONE_BIT  7
// Strap level that selects the multiplexed interface
`define MAPP_SEL_MUX   1'b1
// Level of an output enable while a pin floats
`define MAPP_OE_OFF    1'b1
`define MAPP_OE_ON     1'b0
// Resting level of both strobes, used for their reset values
`define MAPP_STROBE_IDLE 1'b1
`endif

// ### rtl/mapp_pkg.sv
// Types shared by the muxed address programming port.
// Assumes mapp_map.svh sits in the include path.
`include "mapp_map.svh"
package mapp_pkg;
    // Sampled pin levels; five inputs double as address 10 down to 6
    typedef struct packed {
        logic                     interface_select_strap;
        logic                     row_col_strobe;
        logic                     init_oe_n;
        logic                     write_strobe_n;
        logic                     reset_pin_n;
        logic [`MAPP_GPI_W-1:0]   board_general_inputs;
        logic                     write_protect_pin;
        logic                     top_sector_lock_pin;
        logic [3:0]               device_select_straps;
        logic [`MAPP_DATA_W-1:0]  data;
    } mapp_pins_t;
    // Read source chosen by the command logic
    typedef enum logic [2:0] {
        MAPP_RD_ARRAY  = 3'h1,
        MAPP_RD_STATUS = 3'h2,
        MAPP_RD_IDENT  = 3'h4
    } mapp_rd_mode_t;
    // Results handed to the command and array logic
    typedef struct packed {
        logic [`MAPP_ADDR_W-1:0]  array_addr;
        logic [`MAPP_DATA_W-1:0]  write_data;
        logic                     write_pulse;
        logic                     core_reset;
        logic [`MAPP_GPI_W-1:0]   gpi_value;
    } mapp_core_t;
    // Write sequencer states
    typedef enum logic [2:0] {
        MAPP_ST_RESET = 3'h1,
        MAPP_ST_IDLE  = 3'h2,
        MAPP_ST_WRITE = 3'h4
    } mapp_st_t;
endpackage

// ### rtl/mapp_top.sv
// Pin front end of the muxed address programming port.
// Assumes command decoding, status and array sit behind the core side.
`timescale 1ns/1ns
`include "mapp_map.svh"

// Notes on behaviour
// R1: Strap low selects the bus interface, strap high the muxed interface.
// R2: Strobe falling edge captures the eleven address inputs as bits 10..0.
// R3: Strobe rising edge captures address bits 18..11 from the inputs.
// R4: Write data bytes on the eight data lines are held in a latch.
// R5: Reads drive array, status or identifier bytes per the read mode.
// R6: Data lines float while output enable is high; driven only when low.
// R7: Ready output copies status bit 7 in muxed mode.
// R8: Five board input levels are readable through an input register.
// R9: Board keeps those inputs steady across the register read.
// R10: In muxed mode the five board inputs are address 10 down to 6.
// R11: Reserved pins become ready output and data lines 7 down to 4.
// R12: Writes happen only under control of the write strobe.
// R13: Reset pin low blocks writes, resets the core and floats data.
// R14: Bus mode init acts as reset; muxed mode init is output enable.
// R15: Straps are address 3..0, lock pin 4, protect pin 5, bus data 3..0.
// R16: Combined 19-bit address is kept until the next strobe rise.
module mapp_top
(
    // Clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    // Pins from the programmer
    input  wire mapp_pkg::mapp_pins_t      pins,
    // Pins toward the programmer
    output logic [`MAPP_DATA_W-1:0]        data_out,
    output logic                           low_data_oe_n,
    output logic                           high_data_oe_n,
    output logic                           operation_done_output,
    output logic                           done_oe_n,
    // Core side
    input  wire logic [`MAPP_DATA_W-1:0]   array_data,
    input  wire logic [`MAPP_DATA_W-1:0]   status_data,
    input  wire logic [`MAPP_DATA_W-1:0]   ident_data,
    input  wire mapp_pkg::mapp_rd_mode_t   read_mode,
    input  wire logic                      gpi_read_hold,
    output mapp_pkg::mapp_core_t           core
);

    // Whole module state
    typedef struct packed {
        mapp_pkg::mapp_st_t          st;
        mapp_pkg::mapp_pins_t        s1;
        mapp_pkg::mapp_pins_t        s2;
        logic                        rc_prev;
        logic                        we_prev;
        logic [`MAPP_ROW_W-1:0]      row;
        mapp_pkg::mapp_core_t        core;
        logic [`MAPP_DATA_W-1:0]     dq;
        logic                        lo_oe_n;
        logic                        hi_oe_n;
        logic                        done;
        logic                        done_oe_n;
    } mapp_state_t;

    mapp_state_t                q;
    mapp_state_t                next_q;
    logic                       mux;
    logic                       rst_hit;
    logic                       rc_fall;
    logic                       rc_rise;
    logic                       we_rise;
    logic [`MAPP_ROW_W-1:0]     a_pins;

    // Decoded pin events; all read the second sync stage only
    always_comb
    begin
        mux     = (q.s2.interface_select_strap == `MAPP_SEL_MUX);       // see R1
        // Bus mode init doubles as reset, muxed mode init is enable
        rst_hit = !q.s2.reset_pin_n || (!mux && !q.s2.init_oe_n);      // see R14
        rc_fall = q.rc_prev && !q.s2.row_col_strobe;
        rc_rise = !q.rc_prev && q.s2.row_col_strobe;
        we_rise = !q.we_prev && q.s2.write_strobe_n;
        // Shared pins form the address inputs
        a_pins  = {q.s2.board_general_inputs,                           // see R10
                   q.s2.write_protect_pin,                              // see R15
                   q.s2.top_sector_lock_pin,
                   q.s2.device_select_straps};
    end

    // Next state
    always_comb
    begin
        next_q                  = q;
        next_q.s1               = pins;
        next_q.s2               = q.s1;
        next_q.rc_prev          = q.s2.row_col_strobe;
        next_q.we_prev          = q.s2.write_strobe_n;
        next_q.core.write_pulse = 1'b0;
        next_q.core.core_reset  = rst_hit;                              // see R13

        // Write sequencer; data is latched while the strobe is low
        case (q.st)
            mapp_pkg::MAPP_ST_RESET:
            begin
                if (!rst_hit)
                    next_q.st = mapp_pkg::MAPP_ST_IDLE;
            end
            mapp_pkg::MAPP_ST_IDLE:
            begin
                if (rst_hit)
                    next_q.st = mapp_pkg::MAPP_ST_RESET;
                else if (mux && !q.s2.write_strobe_n)
                begin
                    next_q.st              = mapp_pkg::MAPP_ST_WRITE;   // see R12
                    next_q.core.write_data = q.s2.data;                 // see R4
                end
            end
            mapp_pkg::MAPP_ST_WRITE:
            begin
                if (rst_hit)
                    next_q.st = mapp_pkg::MAPP_ST_RESET;                // see R13
                else if (!mux)
                    next_q.st = mapp_pkg::MAPP_ST_IDLE;
                else if (q.s2.write_strobe_n)
                begin
                    // Strobe rise hands the held byte to the core
                    next_q.st               = mapp_pkg::MAPP_ST_IDLE;
                    next_q.core.write_pulse = 1'b1;                     // see R12
                end
                else
                    next_q.core.write_data = q.s2.data;                 // see R4
            end
            default:
                next_q.st = mapp_pkg::MAPP_ST_RESET;
        endcase

        // Two-phase address capture; the pair only updates on a rise
        if (mux && !rst_hit)
        begin
            if (rc_fall)
                next_q.row = a_pins;                                    // see R2
            if (rc_rise)
                next_q.core.array_addr = {a_pins[`MAPP_COL_W-1:0],      // see R3
                                          q.row};                       // see R16
        end

        // Read drive; held off during a write to avoid a fight
        if (mux && !rst_hit && !q.s2.init_oe_n && q.s2.write_strobe_n)
        begin
            next_q.lo_oe_n = `MAPP_OE_ON;                               // see R6
            next_q.hi_oe_n = `MAPP_OE_ON;                               // see R11
        end
        else
        begin
            next_q.lo_oe_n = `MAPP_OE_OFF;                              // see R6
            next_q.hi_oe_n = `MAPP_OE_OFF;
        end
        case (read_mode)
            mapp_pkg::MAPP_RD_STATUS: next_q.dq = status_data;          // see R5
            mapp_pkg::MAPP_RD_IDENT:  next_q.dq = ident_data;
            default:                  next_q.dq = array_data;
        endcase

        // Ready pin exists only in muxed mode
        next_q.done      = status_data[`MAPP_DONE_BIT];                 // see R7
        next_q.done_oe_n = mux ? `MAPP_OE_ON : `MAPP_OE_OFF;            // see R11

        // Input register freezes while the bus reads it
        if (!gpi_read_hold)
            next_q.core.gpi_value = q.s2.board_general_inputs;          // see R8
    end

    // State register; synchronous reset
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            q                 <= '0;
            q.st              <= mapp_pkg::MAPP_ST_RESET;
            q.lo_oe_n         <= `MAPP_OE_OFF;
            q.hi_oe_n         <= `MAPP_OE_OFF;
            q.done_oe_n       <= `MAPP_OE_OFF;
            q.core.core_reset <= 1'b1;
            // Strobes rest high; a low reset value would fake an edge later
            q.s1.row_col_strobe <= `MAPP_STROBE_IDLE;
            q.s2.row_col_strobe <= `MAPP_STROBE_IDLE;
            q.rc_prev           <= `MAPP_STROBE_IDLE;
            q.s1.write_strobe_n <= `MAPP_STROBE_IDLE;
            q.s2.write_strobe_n <= `MAPP_STROBE_IDLE;
            q.we_prev           <= `MAPP_STROBE_IDLE;
        end
        else
            q <= next_q;
    end

    // Outputs straight from flops
    assign data_out              = q.dq;
    assign low_data_oe_n         = q.lo_oe_n;
    assign high_data_oe_n        = q.hi_oe_n;
    assign operation_done_output = q.done;
    assign done_oe_n             = q.done_oe_n;
    assign core                  = q.core;

    // Checks
    sequence fall_s;
        mux && !rst_hit && rc_fall;
    endsequence

    sequence rise_s;
        mux && !rst_hit && rc_rise;
    endsequence

    sequence write_done_s;
        (q.st == mapp_pkg::MAPP_ST_WRITE) && mux && !rst_hit && we_rise;
    endsequence

    row_capture_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R2
        fall_s |=> q.row == $past(a_pins))
        else $error("row address not captured on strobe fall");

    col_capture_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R3
        rise_s |=> core.array_addr == {$past(a_pins[`MAPP_COL_W-1:0]), $past(q.row)})
        else $error("column address not captured on strobe rise");

    addr_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R16
        !(mux && !rst_hit && rc_rise) |=> $stable(core.array_addr))
        else $error("array address moved without a strobe rise");

    bus_mode_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R1
        !mux |=> low_data_oe_n && high_data_oe_n && !core.write_pulse)
        else $error("muxed activity while bus mode selected");

    oe_float_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R6
        q.s2.init_oe_n |=> low_data_oe_n && high_data_oe_n)
        else $error("data driven while output enable high");

    read_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R5
        (mux && !rst_hit && !q.s2.init_oe_n && q.s2.write_strobe_n
         && read_mode == mapp_pkg::MAPP_RD_STATUS)
        |=> !low_data_oe_n && data_out == $past(status_data))
        else $error("status byte not driven during read");

    done_copy_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R7
        mux |=> !done_oe_n && operation_done_output == $past(status_data[`MAPP_DONE_BIT]))
        else $error("ready pin does not follow status bit");

    write_strobe_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R12
        core.write_pulse |-> $past(we_rise) && $past(mux))
        else $error("write issued without write strobe rise");

    write_data_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R4
        write_done_s |=> core.write_pulse
                         && core.write_data == $past(q.core.write_data))
        else $error("held write byte lost at strobe rise");

    reset_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R13
        (!q.s2.reset_pin_n ##1 !q.s2.reset_pin_n)
        |-> (core.core_reset && !core.write_pulse && low_data_oe_n)[*2])
        else $error("reset pin did not block and float");

    init_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R14
        (!mux && !q.s2.init_oe_n) |=> core.core_reset)
        else $error("init in bus mode not treated as reset");

    gpi_track_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R8
        !gpi_read_hold |=> core.gpi_value == $past(q.s2.board_general_inputs))
        else $error("input register not tracking board inputs");

    // Reset pin and bus mode both keep the core from seeing a write
    write_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R13
        (rst_hit || !mux) |=> !core.write_pulse)
        else $error("write pulse while reset pin low or bus mode");

    reset_float_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R13
        !q.s2.reset_pin_n |=> high_data_oe_n)
        else $error("upper data lines driven while reset pin low");

    write_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R4
        ((q.st == mapp_pkg::MAPP_ST_WRITE) && mux && !rst_hit && !q.s2.write_strobe_n)
        |=> core.write_data == $past(q.s2.data))
        else $error("write byte not latched while strobe low");

    // Each read source reaches the lines once the read is on
    array_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R5
        (mux && !rst_hit && !q.s2.init_oe_n && q.s2.write_strobe_n
         && read_mode == mapp_pkg::MAPP_RD_ARRAY)
        |=> !low_data_oe_n && data_out == $past(array_data))
        else $error("array byte not driven during read");

    ident_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R5
        (mux && !rst_hit && !q.s2.init_oe_n && q.s2.write_strobe_n
         && read_mode == mapp_pkg::MAPP_RD_IDENT)
        |=> !low_data_oe_n && data_out == $past(ident_data))
        else $error("identifier byte not driven during read");

    upper_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R11
        (mux && !rst_hit && !q.s2.init_oe_n && q.s2.write_strobe_n)
        |=> !high_data_oe_n)
        else $error("upper data lines not driven during read");

    gpi_freeze_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R8
        gpi_read_hold |=> $stable(core.gpi_value))
        else $error("input register moved while held");

    pin_address_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // see R10
        fall_s |=> q.row[`MAPP_ROW_W-1 -: `MAPP_GPI_W]
                   == $past(q.s2.board_general_inputs))
        else $error("board inputs not taken as upper row bits");

endmodule // mapp_top

// ### testbench/mapp_prog_model.sv
// Programmer model that drives the pins of the muxed port.
// Assumes the bench calls its tasks just after a clock edge.
`timescale 1ns/1ns
module mapp_prog_model
(
    // Clock
    input  wire logic                 sys_clk,
    // Data lines from the device
    input  wire logic [7:0]           data_out,
    input  wire logic                 low_data_oe_n,
    input  wire logic                 high_data_oe_n,
    // Pins toward the device
    output mapp_pkg::mapp_pins_t      pins
);
    mapp_pkg::mapp_pins_t drv;
    logic                 drv_en;
    logic [7:0]           lvl;
    // Released lines have no pull, so they show the inverse of the last byte
    always_comb
    begin
        lvl = drv_en ? drv.data : ~drv.data;
        if (low_data_oe_n === 1'b0) lvl[3:0] = data_out[3:0];
        if (high_data_oe_n === 1'b0) lvl[7:4] = data_out[7:4];
        pins = drv;
        pins.data = lvl;
    end
    // Idle pins: muxed mode, strobes high, out of reset
    initial
    begin
        drv = '0;
        drv.interface_select_strap = 1'b1;
        drv.row_col_strobe = 1'b1;
        drv.init_oe_n = 1'b1;
        drv.write_strobe_n = 1'b1;
        drv.reset_pin_n = 1'b1;
        drv_en = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Eleven address inputs spread over the shared pins
    task automatic put_a(input logic [10:0] a);
        {drv.board_general_inputs, drv.write_protect_pin, drv.top_sector_lock_pin,
         drv.device_select_straps} = a;
    endtask
    // Strobe levels last 4 clocks so the two-flop path sees each one
    task automatic row(input logic [10:0] a);
        put_a(a);
        tick(1);
        drv.row_col_strobe = 1'b0;
        tick(4);
    endtask
    task automatic col(input logic [7:0] a);
        put_a({3'h0, a});
        tick(1);
        drv.row_col_strobe = 1'b1;
        tick(4);
    endtask
    // Data held past the strobe rise until the synchroniser has it
    task automatic write_byte(input logic [7:0] d);
        drv.data = d;
        drv_en = 1'b1;
        drv.write_strobe_n = 1'b0;
        tick(4);
        drv.write_strobe_n = 1'b1;
        tick(3);
        drv_en = 1'b0;
        tick(2);
    endtask
endmodule // mapp_prog_model

// ### testbench/muxed_address_programming_port_tb.sv
// Self-checking bench of the muxed address programming port.
// Assumes mapp_pkg and mapp_top are compiled before it.
`timescale 1ns/1ns
module muxed_address_programming_port_tb;
    logic sys_clk, rst_n, hold, done, done_oe_n, lo_n, hi_n;
    logic [7:0] d_out, arr, sts, idn;
    mapp_pkg::mapp_pins_t pins;
    mapp_pkg::mapp_rd_mode_t mode;
    mapp_pkg::mapp_core_t core;
    int err_count, comparisons, pulses;
    mapp_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .pins(pins), .data_out(d_out),
        .low_data_oe_n(lo_n), .high_data_oe_n(hi_n), .operation_done_output(done),
        .done_oe_n(done_oe_n), .array_data(arr), .status_data(sts), .ident_data(idn),
        .read_mode(mode), .gpi_read_hold(hold), .core(core));
    mapp_prog_model u_prog (.sys_clk(sys_clk), .data_out(d_out), .low_data_oe_n(lo_n),
        .high_data_oe_n(hi_n), .pins(pins));
    // Clock of 8 ns
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Count write pulses so a doubled or lost one shows
    always @(posedge sys_clk) if (core.write_pulse === 1'b1) pulses++;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic t_addr;
        u_prog.row(11'h5a3);
        u_prog.col(8'hc6);
        chk("array_addr", {8'hc6, 11'h5a3}, core.array_addr);
        u_prog.row(11'h7ff);
        chk("array_addr", {8'hc6, 11'h5a3}, core.array_addr);
        u_prog.col(8'h01);
        chk("array_addr", {8'h01, 11'h7ff}, core.array_addr);
        $display("test addr done");
    endtask
    task automatic t_write;
        pulses = 0;
        u_prog.write_byte(8'ha5);
        chk("write_data", 8'ha5, core.write_data);
        u_prog.write_byte(8'h5a);
        chk("write_data", 8'h5a, core.write_data);
        chk("pulses", 2, pulses);
        $display("test write done");
    endtask
    task automatic t_read;
        mapp_pkg::mapp_rd_mode_t m[4] = '{mapp_pkg::MAPP_RD_ARRAY, mapp_pkg::MAPP_RD_STATUS,
            mapp_pkg::MAPP_RD_IDENT, mapp_pkg::mapp_rd_mode_t'(3'h0)};
        // Sources change between reads; an unknown mode falls back to the array
        logic [7:0] av[4] = '{8'h3c, 8'hc3, 8'h3c, 8'hc3};
        logic [7:0] iv[4] = '{8'h96, 8'h96, 8'h69, 8'h69};
        logic [7:0] e[4] = '{8'h3c, 8'h41, 8'h69, 8'hc3};
        for (int i = 0; i < 4; i++)
        begin
            mode = m[i];
            arr = av[i];
            idn = iv[i];
            u_prog.drv.init_oe_n = 1'b0;
            u_prog.tick(5);
            chk("oe_n", 2'b00, {lo_n, hi_n});
            chk("data lines", e[i], pins.data);
            u_prog.drv.init_oe_n = 1'b1;
            u_prog.tick(5);
            chk("oe_n", 2'b11, {lo_n, hi_n});
        end
        $display("test read done");
    endtask
    task automatic t_ready;
        sts = 8'h80;
        u_prog.tick(3);
        chk("done", 2'b10, {done, done_oe_n});
        sts = 8'h7f;
        u_prog.tick(3);
        chk("done", 2'b00, {done, done_oe_n});
        $display("test ready done");
    endtask
    task automatic t_gpi;
        u_prog.put_a({5'h15, 6'h00});
        u_prog.tick(5);
        chk("gpi_value", 5'h15, core.gpi_value);
        hold = 1'b1;
        u_prog.put_a({5'h0a, 6'h00});
        u_prog.tick(5);
        chk("gpi_value", 5'h15, core.gpi_value);
        hold = 1'b0;
        u_prog.tick(5);
        chk("gpi_value", 5'h0a, core.gpi_value);
        $display("test gpi done");
    endtask
    // Bus mode and reset pin both refuse captures, writes and reads
    task automatic t_refuse(input bit use_reset);
        pulses = 0;
        if (use_reset) u_prog.drv.reset_pin_n = 1'b0;
        else u_prog.drv.interface_select_strap = 1'b0;
        u_prog.tick(5);
        u_prog.row(11'h123);
        u_prog.col(8'h45);
        chk("array_addr", {8'h01, 11'h7ff}, core.array_addr);
        u_prog.write_byte(8'h77);
        u_prog.drv.init_oe_n = 1'b0;
        u_prog.tick(5);
        chk("pulses", 0, pulses);
        chk("oe_n", 2'b11, {lo_n, hi_n});
        chk("core_reset", 1, core.core_reset);
        chk("done_oe_n", {31'h0, !use_reset}, done_oe_n);
        u_prog.drv.init_oe_n = 1'b1;
        u_prog.drv.reset_pin_n = 1'b1;
        u_prog.drv.interface_select_strap = 1'b1;
        u_prog.tick(6);
        chk("core_reset", 0, core.core_reset);
        $display("test refuse done");
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog well past the roughly 180 cycles the tests need
    initial
    begin
        #40000;
        err_count++;
        stop_test();
    end
    initial
    begin
        {rst_n, hold, sts, idn, arr, err_count, comparisons, pulses} = '0;
        mode = mapp_pkg::MAPP_RD_ARRAY;
        arr = 8'h3c;
        sts = 8'h41;
        idn = 8'h96;
        u_prog.tick(6);
        rst_n = 1'b1;
        u_prog.tick(4);
        t_addr();
        t_write();
        t_read();
        t_ready();
        t_gpi();
        t_refuse(1'b0);
        t_refuse(1'b1);
        stop_test();
    end
endmodule // muxed_address_programming_port_tb
